/* rtw_pkg.sv */
// package: constants and types for the reset time-out and watchdog block
package rtw_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] RTW_ADDR_RESET_CAUSE = 8'h8E;
    localparam logic [7:0] RTW_ADDR_CPU_STATUS = 8'h83;
    localparam logic [7:0] RTW_ADDR_WDT_CONTROL = 8'h90;
    localparam logic [7:0] RTW_ADDR_WDT_CONFIG = 8'h91;

    localparam int RTW_BIT_BROWNOUT = 0;
    localparam int RTW_BIT_POWER_ON = 1;
    localparam int RTW_BIT_POWERDOWN = 3;
    localparam int RTW_BIT_TIMEOUT = 4;
    localparam int RTW_BIT_SOFT_EN = 0;
    localparam int RTW_BIT_LF_STABLE = 7;
    localparam int RTW_PS_LSB = 1;
    localparam int RTW_PS_MSB = 4;
    localparam logic [7:0] RTW_WDT_CONTROL_RESET = 8'h08;
    localparam logic [2:0] RTW_PRESCALE_RATE_RESET = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int RTW_CLK_MHZ = 200;
    localparam int RTW_POWER_UP_DELAY_MS = 64;
    localparam int RTW_POWER_UP_CYCLES = RTW_POWER_UP_DELAY_MS * RTW_CLK_MHZ * 1000;
    localparam int RTW_OST_PERIODS = 1024;
    localparam int RTW_LF_OSC_KHZ = 31;
    localparam int RTW_WDT_BASE_BITS = 5;
    localparam int RTW_WDT_PRE16_BITS = 16;
    localparam int RTW_WDT_PRE8_BITS = 8;
    localparam int RTW_WDT_CNT_BITS = RTW_WDT_BASE_BITS + RTW_WDT_PRE16_BITS + RTW_WDT_PRE8_BITS;
    localparam int RTW_WDT_MIN_MS = 1;
    localparam int RTW_WDT_MAX_S = 268;

    // ------------------------------------------------------------
    // oscillator modes and start-up states
    // ------------------------------------------------------------
    localparam logic [2:0] RTW_OSC_LP = 3'h0;
    localparam logic [2:0] RTW_OSC_XT = 3'h1;
    localparam logic [2:0] RTW_OSC_HS = 3'h2;
    localparam logic [2:0] RTW_OSC_EC = 3'h3;
    localparam logic [2:0] RTW_OSC_INT = 3'h4;
    localparam logic [2:0] RTW_OSC_RC = 3'h6;
    localparam logic [1:0] RTW_BOR_DISABLED = 2'h0;

    typedef enum logic [1:0] {
        RTW_ST_POR,
        RTW_ST_POWER_UP_TIMER,
        RTW_ST_OST,
        RTW_ST_RUN
    } rtw_state_type;

endpackage

/* rtw_sync.sv */
// three-flop input synchroniser with agreement filter
`timescale 1ns/100ps
module rtw_sync
    import rtw_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ------------------------------------------------------------
    // chain: the first flop feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                sync_out <= s3_reg;
            end
        end
    end
endmodule // rtw_sync

/* rtw_top.sv */
// reset time-out sequencer, reset-cause flags and watchdog
// Function
// - power-up delay after POR, then OSC_STARTUP_TIMER
// - external clock, timer disabled: no delay
// - delays run regardless of master clear
// - crystal modes add 1024 oscillator periods
// - internal oscillator runs code during OSC_STARTUP_TIMER
// - reset-cause register at address 8Eh
// - brown-out flag cleared by brown-out reset
// - brown-out flag meaningless when detector off
// - power-on flag cleared by power-on reset
// - master clear in run keeps flags
// - sleep/watchdog resets set timeout, powerdown flags
// - watchdog on 31 kHz, 16+8 bit prescalers
// - time-out selectable 1 ms to 268 s; the longest tap the code selects, bit 28, gives about 8659 s at 31 kHz
// - control resets to prescale 0100, disabled
// - stable flag ignores watchdog oscillator use
// - watchdog held in reset during OSC_STARTUP_TIMER
// - config enable forces watchdog on
// - soft enable starts and stops watchdog
// - six conditions besides rstn clear the watchdog count
// - crystal sleep exit: hold until OSC_STARTUP_TIMER ends
`timescale 1ns/100ps
module rtw_top
    import rtw_pkg::*;
#(
    parameter int POWER_UP_CYCLES = RTW_POWER_UP_CYCLES
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic por_pulse,
    input wire logic brownout_event,
    input wire logic master_clear_pin_n,
    input wire logic sleep_mode,
    input wire logic wake_event,
    input wire logic osc_clk_in,
    input wire logic low_freq_internal_osc,
    input wire logic [2:0] osc_mode_cfg,
    input wire logic timer1_osc_input_sel,
    input wire logic power_up_timer_enable_n,
    input wire logic [1:0] brownout_enable_cfg,
    input wire logic watchdog_config_enable,
    input wire logic two_speed_cfg,
    input wire logic fail_safe_cfg,
    input wire logic osc_fail,
    input wire logic lf_osc_req,
    input wire logic watchdog_clear_instr,
    input wire logic prescaler_assign,
    input wire logic [2:0] prescaler_rate,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic core_run,
    output logic use_internal_osc,
    output logic watchdog_reset,
    output logic watchdog_wake
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic lf_sync;
    logic osc_sync;
    logic master_clear_pin_low_sync;

    rtw_sync u_sync_lf (
        .mclk(mclk),
        .rstn(rstn),
        .async_in(low_freq_internal_osc),
        .sync_out(lf_sync)
    );

    rtw_sync u_sync_osc (
        .mclk(mclk),
        .rstn(rstn),
        .async_in(osc_clk_in),
        .sync_out(osc_sync)
    );

    rtw_sync u_sync_master_clear_pin (
        .mclk(mclk),
        .rstn(rstn),
        // inverted so that the synchroniser's reset state means the pin is released
        .async_in(!master_clear_pin_n),
        .sync_out(master_clear_pin_low_sync)
    );

    logic lf_prev_reg;
    logic osc_prev_reg;
    logic lf_tick;
    logic osc_tick;
    assign lf_tick = lf_sync & ~lf_prev_reg;
    assign osc_tick = osc_sync & ~osc_prev_reg;

    // ------------------------------------------------------------
    // start-up sequencer
    // ------------------------------------------------------------
    rtw_state_type state_reg;
    rtw_state_type state_next;
    logic [31:0] power_up_timer_cnt_reg;
    logic [10:0] ost_cnt_reg;
    logic crystal_mode_sel;
    logic need_ost;
    logic need_power_up_timer;
    logic power_up_timer_done;
    logic ost_done;
    logic sleep_reg;
    logic sleep_exit;
    logic wdt_timeout;

    assign crystal_mode_sel = (osc_mode_cfg == RTW_OSC_XT) || (osc_mode_cfg == RTW_OSC_HS)
        || ((osc_mode_cfg == RTW_OSC_LP) && !timer1_osc_input_sel);
    assign need_ost = crystal_mode_sel;
    assign need_power_up_timer = !power_up_timer_enable_n;
    assign power_up_timer_done = (power_up_timer_cnt_reg >= 32'(POWER_UP_CYCLES - 1));
    assign ost_done = osc_tick && (ost_cnt_reg == 11'(RTW_OST_PERIODS - 1));
    assign sleep_exit = sleep_reg && !sleep_mode;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RTW_ST_POR: begin
                // sequence begins only when the power-on pulse ends
                if (!por_pulse) begin
                    if (need_power_up_timer) begin
                        state_next = RTW_ST_POWER_UP_TIMER;
                    end else if (need_ost) begin
                        state_next = RTW_ST_OST;
                    end else begin
                        state_next = RTW_ST_RUN;
                    end
                end
            end
            RTW_ST_POWER_UP_TIMER: begin
                if (power_up_timer_done) begin
                    state_next = need_ost ? RTW_ST_OST : RTW_ST_RUN;
                end
            end
            RTW_ST_OST: begin
                if (ost_done) begin
                    state_next = RTW_ST_RUN;
                end
            end
            RTW_ST_RUN: begin
                // brown-out re-runs the delays; wake re-runs only OSC_STARTUP_TIMER, in crystal modes
                if (brownout_event) begin
                    state_next = need_power_up_timer ? RTW_ST_POWER_UP_TIMER : (need_ost ? RTW_ST_OST : RTW_ST_RUN);
                end else if (sleep_exit && need_ost) begin
                    state_next = RTW_ST_OST;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg <= RTW_ST_POR;
            power_up_timer_cnt_reg <= '0;
            ost_cnt_reg <= '0;
            lf_prev_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end else begin
            state_reg <= por_pulse ? RTW_ST_POR : state_next;
            power_up_timer_cnt_reg <= (state_reg == RTW_ST_POWER_UP_TIMER && !power_up_timer_done) ? power_up_timer_cnt_reg + 32'h1 : 32'h0;
            ost_cnt_reg <= (state_reg == RTW_ST_OST) ? ost_cnt_reg + 11'(osc_tick) : 11'h0;
            lf_prev_reg <= lf_sync;
            osc_prev_reg <= osc_sync;
            sleep_reg <= sleep_mode;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic brownout_flag_reg;
    logic power_on_flag_reg;
    logic timeout_flag_reg;
    logic powerdown_flag_reg;
    logic soft_en_reg;
    logic [3:0] ps_field_reg;
    logic lf_stable_reg;
    logic wr_cause;
    logic wr_status;
    logic wr_wdt;
    logic master_clear_pin_low;
    logic wdt_enabled;

    assign wr_cause = reg_write && (reg_addr == RTW_ADDR_RESET_CAUSE);
    assign wr_status = reg_write && (reg_addr == RTW_ADDR_CPU_STATUS);
    assign wr_wdt = reg_write && (reg_addr == RTW_ADDR_WDT_CONTROL);
    assign master_clear_pin_low = master_clear_pin_low_sync;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            brownout_flag_reg <= 1'b0;
            power_on_flag_reg <= 1'b0;
            timeout_flag_reg <= 1'b1;
            powerdown_flag_reg <= 1'b1;
        end else if (por_pulse) begin
            power_on_flag_reg <= 1'b0;
            timeout_flag_reg <= 1'b1;
            powerdown_flag_reg <= 1'b1;
        end else if (brownout_event && brownout_enable_cfg != RTW_BOR_DISABLED) begin
            // with detector off the flag is left as is
            brownout_flag_reg <= 1'b0;
            timeout_flag_reg <= 1'b1;
            powerdown_flag_reg <= 1'b1;
        end else if (wdt_timeout) begin
            timeout_flag_reg <= 1'b0;
            powerdown_flag_reg <= sleep_mode ? 1'b0 : powerdown_flag_reg;
        end else if (master_clear_pin_low && sleep_mode) begin
            timeout_flag_reg <= 1'b1;
            powerdown_flag_reg <= 1'b0;
        end else if (!master_clear_pin_low) begin
            // master clear while running leaves every flag
            if (wr_cause) begin
                brownout_flag_reg <= reg_wdata[RTW_BIT_BROWNOUT];
                power_on_flag_reg <= reg_wdata[RTW_BIT_POWER_ON];
            end
            if (wr_status) begin
                timeout_flag_reg <= reg_wdata[RTW_BIT_TIMEOUT];
                powerdown_flag_reg <= reg_wdata[RTW_BIT_POWERDOWN];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn || por_pulse || brownout_event || master_clear_pin_low || wdt_timeout) begin
            soft_en_reg <= RTW_WDT_CONTROL_RESET[RTW_BIT_SOFT_EN];
            ps_field_reg <= RTW_WDT_CONTROL_RESET[RTW_PS_MSB:RTW_PS_LSB];
        end else if (wr_wdt) begin
            soft_en_reg <= reg_wdata[RTW_BIT_SOFT_EN];
            ps_field_reg <= reg_wdata[RTW_PS_MSB:RTW_PS_LSB];
        end
    end

    // stable flag follows only software requests, not watchdog use
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            lf_stable_reg <= 1'b0;
        end else begin
            lf_stable_reg <= lf_osc_req && lf_tick ? 1'b1 : (lf_osc_req ? lf_stable_reg : 1'b0);
        end
    end

    logic [7:0] rd_mux;
    assign rd_mux = (reg_addr == RTW_ADDR_RESET_CAUSE) ?
            {6'h00, power_on_flag_reg, brownout_flag_reg} :
        (reg_addr == RTW_ADDR_CPU_STATUS) ?
            {3'h0, timeout_flag_reg, powerdown_flag_reg, 3'h0} :
        (reg_addr == RTW_ADDR_WDT_CONTROL) ? {3'h0, ps_field_reg, soft_en_reg} :
        (reg_addr == RTW_ADDR_WDT_CONFIG) ? {lf_stable_reg, 7'h00} : 8'h00;

    // ------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------
    logic [RTW_WDT_CNT_BITS-1:0] wdt_cnt_reg;
    logic wdt_clear;
    logic [4:0] tap_sel;
    logic wdt_tap;
    logic wdt_tap_prev_reg;

    assign wdt_enabled = watchdog_config_enable || soft_en_reg;
    assign wdt_clear = !wdt_enabled || watchdog_clear_instr || osc_fail
        || (sleep_exit && !need_ost)
        || por_pulse || (state_reg != RTW_ST_RUN);
    // base 5 bits then 16-bit prescale selection, plus 8-bit shared stage
    assign tap_sel = 5'(RTW_WDT_BASE_BITS) + 5'(ps_field_reg)
        + (prescaler_assign ? 5'(prescaler_rate) + 5'h1 : 5'h0);
    assign wdt_tap = wdt_cnt_reg[tap_sel];
    assign wdt_timeout = wdt_tap && !wdt_tap_prev_reg && !wdt_clear;

    always_ff @(posedge mclk) begin
        if (!rstn || wdt_clear) begin
            wdt_cnt_reg <= '0;
            wdt_tap_prev_reg <= 1'b0;
        end else begin
            wdt_cnt_reg <= wdt_cnt_reg + RTW_WDT_CNT_BITS'(lf_tick);
            wdt_tap_prev_reg <= wdt_tap;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            core_run <= 1'b0;
            use_internal_osc <= 1'b0;
            watchdog_reset <= 1'b0;
            watchdog_wake <= 1'b0;
        end else begin
            reg_rdata <= reg_read ? rd_mux : 8'h00;
            // execution starts as soon as pin rises after delays
            core_run <= !por_pulse && !master_clear_pin_low && ((state_next == RTW_ST_RUN)
                || (state_reg == RTW_ST_OST && (two_speed_cfg || fail_safe_cfg)));
            use_internal_osc <= (state_reg == RTW_ST_OST) && (two_speed_cfg || fail_safe_cfg);
            watchdog_reset <= wdt_timeout && !sleep_mode;
            watchdog_wake <= wdt_timeout && sleep_mode;
        end
    end
endmodule // rtw_top

/* rtw_checker.sv */
// checker: port-level assertions for the reset time-out and watchdog block
`timescale 1ns/100ps
module rtw_checker
    import rtw_pkg::*;
#(
    parameter int POWER_UP_CYCLES = 50
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic por_pulse,
    input wire logic master_clear_pin_n,
    input wire logic sleep_mode,
    input wire logic [2:0] osc_mode_cfg,
    input wire logic power_up_timer_enable_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic core_run,
    input wire logic watchdog_reset,
    input wire logic watchdog_wake
);
    // ------------------------------------------------------------
    // cycles since the last power-on pulse, saturating
    // ------------------------------------------------------------
    logic [31:0] since_por_reg;
    logic [31:0] since_por_next;
    assign since_por_next = (since_por_reg == 32'hFFFFFFFF) ? since_por_reg : since_por_reg + 32'h1;
    // a plain reset makes the count vacuous until the next power-on pulse
    always_ff @(posedge mclk) begin
        if (por_pulse) begin
            since_por_reg <= 32'h0;
        end else if (!rstn) begin
            since_por_reg <= 32'hFFFFFFFF;
        end else begin
            since_por_reg <= since_por_next;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_rdata_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read answer");
    property p_cause_map; reg_read && reg_addr == RTW_ADDR_RESET_CAUSE |=> reg_rdata[7:2] == 6'h00; endproperty
    a_cause_map: assert property (p_cause_map) else $error("reset cause upper bits not zero");
    property p_unmapped;
        reg_read && !(reg_addr inside {8'h8E, 8'h83, 8'h90, 8'h91}) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");
    property p_por_hold; por_pulse |=> !core_run; endproperty
    a_por_hold: assert property (p_por_hold) else $error("execution during power-on pulse");
    property p_power_up_timer_min; core_run && !power_up_timer_enable_n |-> since_por_reg >= 32'(POWER_UP_CYCLES - 1); endproperty
    a_power_up_timer_min: assert property (p_power_up_timer_min) else $error("execution before power-up delay ended");
    property p_ec_fast;
        $fell(por_pulse) && osc_mode_cfg == RTW_OSC_EC && power_up_timer_enable_n && master_clear_pin_n
            |-> ##[1:12] core_run;
    endproperty
    a_ec_fast: assert property (p_ec_fast) else $error("delay applied with timer disabled");
    property p_wd_quiet_por; por_pulse |=> !watchdog_reset && !watchdog_wake; endproperty
    a_wd_quiet_por: assert property (p_wd_quiet_por) else $error("watchdog fired during start-up");
    property p_wake_sleep; watchdog_wake |-> $past(sleep_mode); endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("watchdog wake while awake");
    property p_reset_awake; watchdog_reset |-> !$past(sleep_mode); endproperty
    a_reset_awake: assert property (p_reset_awake) else $error("watchdog reset while asleep");
endmodule // rtw_checker

bind rtw_top rtw_checker #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_rtw_checker (.mclk, .rstn, .por_pulse,
    .master_clear_pin_n, .sleep_mode, .osc_mode_cfg, .power_up_timer_enable_n, .reg_addr, .reg_read,
    .reg_rdata, .core_run, .watchdog_reset, .watchdog_wake);

/* testbench.sv */
// testbench: directed scenarios for the reset time-out and watchdog block
`timescale 1ns/100ps
module testbench;
    import rtw_pkg::*;
    localparam int PUC = 50;
    logic mclk, rstn, por_pulse, brownout_event, master_clear_pin_n, sleep_mode, wake_event;
    logic osc_clk_in, low_freq_internal_osc, timer1_osc_input_sel, power_up_timer_enable_n;
    logic watchdog_config_enable, two_speed_cfg, fail_safe_cfg, osc_fail, lf_osc_req, watchdog_clear_instr;
    logic prescaler_assign, reg_write, reg_read, core_run, use_internal_osc, watchdog_reset, watchdog_wake;
    logic [2:0] osc_mode_cfg, prescaler_rate;
    logic [1:0] brownout_enable_cfg;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    int mismatches, num_checks, n, wd_cnt, base;
    logic seen_int;
    rtw_top #(.POWER_UP_CYCLES(PUC)) u_rtw_top (.mclk, .rstn, .por_pulse, .brownout_event, .master_clear_pin_n,
        .sleep_mode, .wake_event, .osc_clk_in, .low_freq_internal_osc, .osc_mode_cfg, .timer1_osc_input_sel,
        .power_up_timer_enable_n, .brownout_enable_cfg, .watchdog_config_enable, .two_speed_cfg, .fail_safe_cfg,
        .osc_fail, .lf_osc_req, .watchdog_clear_instr, .prescaler_assign, .prescaler_rate, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .core_run, .use_internal_osc, .watchdog_reset, .watchdog_wake);
    // ------------------------------------------------------------
    // clocks: system 5 ns, oscillator 20 ns, fast stand-in for the 31 kHz source 40 ns
    // ------------------------------------------------------------
    initial begin mclk = 0; forever #2.5 mclk = ~mclk; end
    initial begin osc_clk_in = 0; forever #10 osc_clk_in = ~osc_clk_in; end
    initial begin low_freq_internal_osc = 0; forever #20 low_freq_internal_osc = ~low_freq_internal_osc; end
    always @(posedge mclk) if (watchdog_reset === 1'b1) wd_cnt++;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        // the answer stands until this next edge replaces it
        @(posedge mclk);
        check(nm, {8'h00, reg_rdata & m}, {8'h00, e});
    endtask
    task automatic cycles(input int c);
        repeat (c) @(posedge mclk);
    endtask
    task automatic pulse_por();
        @(posedge mclk);
        por_pulse <= 1'b1;
        cycles(4);
        por_pulse <= 1'b0;
    endtask
    task automatic wait_run(input int maxc);
        n = 0;
        seen_int = 1'b0;
        while (core_run !== 1'b1) begin
            @(posedge mclk);
            seen_int = seen_int | (use_internal_osc === 1'b1);
            n++;
            if (n > maxc) begin
                mismatches++;
                $display("Error core_run expected 1 seen %b", core_run);
                tally_and_finish();
            end
        end
    endtask
    task automatic wait_evt(input bit wake, input int maxc);
        for (n = 0; n < maxc; n++) begin
            @(posedge mclk);
            if ((wake ? watchdog_wake : watchdog_reset) === 1'b1) break;
        end
        if (n >= maxc) begin
            mismatches++;
            $display("Error watchdog event expected 1 seen 0");
            tally_and_finish();
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(RTW_ADDR_WDT_CONTROL, 8'hFF, RTW_WDT_CONTROL_RESET, "watchdog_control");
        rd(RTW_ADDR_CPU_STATUS, 8'h18, 8'h18, "cpu_status_flags");
        rd(RTW_ADDR_RESET_CAUSE, 8'h03, 8'h00, "reset_cause_flags");
        rd(RTW_ADDR_WDT_CONFIG, 8'h80, 8'h00, "lf_osc_stable_flag");
        rd(8'h00, 8'hFF, 8'h00, "unmapped");
        lf_osc_req <= 1'b1;
        cycles(16);
        rd(RTW_ADDR_WDT_CONFIG, 8'h80, 8'h80, "lf_osc_stable_flag on request");
        lf_osc_req <= 1'b0;
        $display("t_reset done");
    endtask
    task automatic t_por_ec();
        pulse_por();
        wait_run(PUC + 40);
        check("ec power-up delay", n >= PUC - 2 && n <= PUC + 20, 16'h1);
        rd(RTW_ADDR_RESET_CAUSE, 8'h02, 8'h00, "power_on flag");
        wr(RTW_ADDR_RESET_CAUSE, 8'h03);
        @(posedge mclk);
        brownout_event <= 1'b1;
        @(posedge mclk);
        brownout_event <= 1'b0;
        rd(RTW_ADDR_RESET_CAUSE, 8'h03, 8'h02, "brownout flag");
        brownout_enable_cfg <= 2'h0;
        wr(RTW_ADDR_RESET_CAUSE, 8'h03);
        @(posedge mclk);
        brownout_event <= 1'b1;
        @(posedge mclk);
        brownout_event <= 1'b0;
        rd(RTW_ADDR_RESET_CAUSE, 8'h01, 8'h01, "brownout flag detector off");
        brownout_enable_cfg <= 2'h3;
        cycles(4);
        wait_run(PUC + 40);
        master_clear_pin_n <= 1'b0;
        cycles(10);
        master_clear_pin_n <= 1'b1;
        cycles(10);
        rd(RTW_ADDR_RESET_CAUSE, 8'h03, 8'h03, "cause after master clear");
        rd(RTW_ADDR_CPU_STATUS, 8'h18, 8'h18, "status after master clear");
        $display("t_por_ec done");
    endtask
    task automatic t_xt(input logic ts);
        osc_mode_cfg <= RTW_OSC_XT;
        two_speed_cfg <= ts;
        pulse_por();
        wait_run(PUC + 4400);
        check("internal osc during ost", seen_int, ts);
        if (!ts) check("crystal start-up", n >= PUC + 4000 && n <= PUC + 4250, 16'h1);
        osc_mode_cfg <= RTW_OSC_EC;
        two_speed_cfg <= 1'b0;
        $display("t_xt done");
    endtask
    task automatic t_master_clear_pin_hold();
        master_clear_pin_n <= 1'b0;
        pulse_por();
        cycles(PUC + 60);
        check("held by master clear", core_run, 16'h0);
        master_clear_pin_n <= 1'b1;
        wait_run(12);
        check("run on release", n <= 8, 16'h1);
        $display("t_master_clear_pin_hold done");
    endtask
    task automatic t_wdt();
        wr(RTW_ADDR_WDT_CONTROL, 8'h01);
        wait_evt(0, 600);
        check("soft enabled time-out", n >= 200 && n <= 320, 16'h1);
        rd(RTW_ADDR_CPU_STATUS, 8'h10, 8'h00, "timeout flag");
        rd(RTW_ADDR_WDT_CONTROL, 8'hFF, RTW_WDT_CONTROL_RESET, "control reload");
        wait_run(PUC + 40);
        wr(RTW_ADDR_WDT_CONTROL, 8'h01);
        base = wd_cnt;
        for (int i = 0; i < 6; i++) begin
            cycles(150);
            if (i[0]) osc_fail <= 1'b1;
            else watchdog_clear_instr <= 1'b1;
            @(posedge mclk);
            osc_fail <= 1'b0;
            watchdog_clear_instr <= 1'b0;
        end
        wr(RTW_ADDR_WDT_CONTROL, 8'h00);
        cycles(600);
        check("no time-out when cleared or stopped", 16'(wd_cnt - base), 16'h0);
        prescaler_assign <= 1'b1;
        watchdog_config_enable <= 1'b1;
        rd(RTW_ADDR_WDT_CONFIG, 8'h80, 8'h00, "stable flag with watchdog running");
        wait_evt(0, 800);
        watchdog_config_enable <= 1'b0;
        check("forced on with shared stage", n >= 440 && n <= 600, 16'h1);
        prescaler_assign <= 1'b0;
        $display("t_wdt done");
    endtask
    task automatic t_sleep();
        wait_run(PUC + 40);
        sleep_mode <= 1'b1;
        cycles(10);
        master_clear_pin_n <= 1'b0;
        cycles(10);
        master_clear_pin_n <= 1'b1;
        cycles(10);
        rd(RTW_ADDR_CPU_STATUS, 8'h18, 8'h10, "master clear in sleep");
        wr(RTW_ADDR_WDT_CONTROL, 8'h01);
        wait_evt(1, 600);
        check("wake seen", n < 600, 16'h1);
        rd(RTW_ADDR_CPU_STATUS, 8'h18, 8'h00, "wake flags");
        sleep_mode <= 1'b0;
        $display("t_sleep done");
    endtask
    task automatic t_ec_fast();
        power_up_timer_enable_n <= 1'b1;
        pulse_por();
        wait_run(12);
        check("no delay", n <= 3, 16'h1);
        $display("t_ec_fast done");
    endtask
    initial begin
        {rstn, por_pulse, brownout_event, sleep_mode, wake_event, timer1_osc_input_sel} = '0;
        {power_up_timer_enable_n, watchdog_config_enable, two_speed_cfg, fail_safe_cfg, osc_fail} = '0;
        {lf_osc_req, watchdog_clear_instr, prescaler_assign, prescaler_rate, reg_write, reg_read} = '0;
        {reg_addr, reg_wdata, mismatches, num_checks, wd_cnt} = '0;
        master_clear_pin_n = 1'b1;
        osc_mode_cfg = RTW_OSC_EC;
        brownout_enable_cfg = 2'h3;
        cycles(12);
        rstn <= 1'b1;
        t_reset();
        t_por_ec();
        t_xt(1'b0);
        t_xt(1'b1);
        t_master_clear_pin_hold();
        t_wdt();
        t_sleep();
        t_ec_fast();
        tally_and_finish();
    end
    initial begin
        #300000;
        mismatches++;
        tally_and_finish();
    end
endmodule // testbench
